// *** include/ackc_consts.svh ***
`ifndef ACKC_CONSTS_SVH
`define ACKC_CONSTS_SVH
`define ACKC_ADR_CLK_DIV 16'h0408
`define ACKC_ADR_CLK_GATE 16'h0410
`define ACKC_ADR_CLK_SEL 16'h0414
`define ACKC_ADR_DIV_KEY 16'h0420
`define ACKC_ADR_PWR_KEY 16'h0a04
`define ACKC_ADR_OSC_KEY 16'h0a0c
`define ACKC_ADR_OSC_CTL 16'h0a10
`define ACKC_ADR_RST_KEY 16'h0a5c
`define ACKC_ADR_SLOW_TRIM 16'h0a6c
`define ACKC_ADR_CHOP_EN 16'h0a70
`define ACKC_ADR_FAST_CFG 16'h20bc
`define ACKC_ADR_LP_KEY 16'h210c
`define ACKC_ADR_LP_CLK 16'h2110
`define ACKC_ADR_LP_PD 16'h2114
`define ACKC_RST_CLK_DIV 16'h0441
`define ACKC_RST_CLK_GATE 16'h01c0
`define ACKC_RST_CLK_SEL 16'h0000
`define ACKC_RST_OSC_CTL 16'h0003
`define ACKC_RST_SLOW_TRIM 16'h0088
`define ACKC_RST_CHOP_EN 16'h0004
`define ACKC_RST_FAST_CFG 32'h00000034
`define ACKC_RST_LP_CLK 32'h00000000
`define ACKC_RST_LP_PD 32'h00000102
`define ACKC_OSC_UNLOCK 16'hcb14
`define ACKC_LP_UNLOCK 32'h000c59d6
`define ACKC_DIV_LSB 0
`define ACKC_DIV_MSB 5
`define ACKC_DIV_MIN 6'h01
`define ACKC_DIV_MAX 6'h20
`define ACKC_SEL_LSB 0
`define ACKC_SEL_MSB 1
`define ACKC_FAST_32M_BIT 2
`define ACKC_LP_CLK_BIT 0
`endif

// *** include/ackc_pkg.sv ***
package ackc_pkg;
    typedef enum logic [1:0] {
        ACKC_SRC_FAST_OSC,
        ACKC_SRC_XTAL,
        ACKC_SRC_EXT_CLK,
        ACKC_SRC_SLOW_OSC
    } ackc_src_type;
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ackc_bus_type;
    typedef struct packed {
        ackc_src_type sys_src;
        logic [5:0] sys_div;
        logic fast_32m;
        logic adc_32m;
        logic lp_clk_allow;
        logic [31:0] pd_mask;
    } ackc_clk_type;
endpackage

// *** src/ackc_clock_key.sv ***
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "ackc_consts.svh"
module ackc_clock_key
    import ackc_pkg::*;
#(
    parameter bit PIN_B_PRESENT = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire ackc_bus_type bus,
    output logic [31:0] rdata,
    input wire logic slow_osc_tick,
    input wire logic seq_lp_req,
    output ackc_clk_type clk_cfg,
    output logic ext_clk_pin_a_sel,
    output logic ext_clk_pin_b_sel,
    output logic wakeup_timer_tick,
    output logic lp_clk_active
);
    logic [15:0] div_q;
    logic [15:0] gate_q;
    logic [15:0] sel_q;
    logic [15:0] osc_q;
    logic [15:0] trim_q;
    logic [15:0] chop_q;
    logic [31:0] fast_q;
    logic [31:0] lpclk_q;
    logic [31:0] lppd_q;
    logic osc_unlk_q;
    logic lp_unlk_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_d;
    logic [5:0] div_raw;
    logic wr_osc_key;
    logic wr_lp_key;
    logic wr_osc_ctl;
    logic wr_lp_clk;
    logic wr_lp_pd;
    logic wr_div;
    logic wr_gate;
    logic wr_sel;
    logic wr_trim;
    logic wr_chop;
    logic wr_fast;

    assign wr_osc_key = bus.wr && bus.addr == `ACKC_ADR_OSC_KEY;
    assign wr_lp_key = bus.wr && bus.addr == `ACKC_ADR_LP_KEY;
    assign wr_osc_ctl = bus.wr && bus.addr == `ACKC_ADR_OSC_CTL;
    assign wr_lp_clk = bus.wr && bus.addr == `ACKC_ADR_LP_CLK;
    assign wr_lp_pd = bus.wr && bus.addr == `ACKC_ADR_LP_PD;
    assign wr_div = bus.wr && bus.addr == `ACKC_ADR_CLK_DIV;
    assign wr_gate = bus.wr && bus.addr == `ACKC_ADR_CLK_GATE;
    assign wr_sel = bus.wr && bus.addr == `ACKC_ADR_CLK_SEL;
    assign wr_trim = bus.wr && bus.addr == `ACKC_ADR_SLOW_TRIM;
    assign wr_chop = bus.wr && bus.addr == `ACKC_ADR_CHOP_EN;
    assign wr_fast = bus.wr && bus.addr == `ACKC_ADR_FAST_CFG;

    // oscillator key: one-shot unlock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            osc_unlk_q <= 1'b0;
        end else if (wr_osc_key) begin
            osc_unlk_q <= bus.wdata[15:0] == `ACKC_OSC_UNLOCK;
        end else if (bus.wr) begin
            osc_unlk_q <= 1'b0;
        end
    end

    // low power key: stays unlocked until a wrong key
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lp_unlk_q <= 1'b0;
        end else if (wr_lp_key) begin
            lp_unlk_q <= bus.wdata == `ACKC_LP_UNLOCK;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            osc_q <= `ACKC_RST_OSC_CTL;
        end else if (wr_osc_ctl && osc_unlk_q) begin
            osc_q <= bus.wdata[15:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lpclk_q <= `ACKC_RST_LP_CLK;
        end else if (wr_lp_clk && lp_unlk_q) begin
            lpclk_q <= bus.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lppd_q <= `ACKC_RST_LP_PD;
        end else if (wr_lp_pd && lp_unlk_q) begin
            lppd_q <= bus.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q <= `ACKC_RST_CLK_DIV;
        end else if (wr_div) begin
            div_q <= bus.wdata[15:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_q <= `ACKC_RST_CLK_GATE;
        end else if (wr_gate) begin
            gate_q <= bus.wdata[15:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_q <= `ACKC_RST_CLK_SEL;
        end else if (wr_sel) begin
            sel_q <= bus.wdata[15:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trim_q <= `ACKC_RST_SLOW_TRIM;
        end else if (wr_trim) begin
            trim_q <= bus.wdata[15:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chop_q <= `ACKC_RST_CHOP_EN;
        end else if (wr_chop) begin
            chop_q <= bus.wdata[15:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fast_q <= `ACKC_RST_FAST_CFG;
        end else if (wr_fast) begin
            fast_q <= bus.wdata;
        end
    end

    // read mux, key registers read zero
    always_comb begin
        rd_d = 32'h00000000;
        case (bus.addr)
            `ACKC_ADR_CLK_DIV: rd_d = {16'h0000, div_q};
            `ACKC_ADR_CLK_GATE: rd_d = {16'h0000, gate_q};
            `ACKC_ADR_CLK_SEL: rd_d = {16'h0000, sel_q};
            `ACKC_ADR_OSC_CTL: rd_d = {16'h0000, osc_q};
            `ACKC_ADR_SLOW_TRIM: rd_d = {16'h0000, trim_q};
            `ACKC_ADR_CHOP_EN: rd_d = {16'h0000, chop_q};
            `ACKC_ADR_FAST_CFG: rd_d = fast_q;
            `ACKC_ADR_LP_CLK: rd_d = lpclk_q;
            `ACKC_ADR_LP_PD: rd_d = lppd_q;
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (bus.rd) begin
            rdata_q <= rd_d;
        end else begin
            rdata_q <= 32'h00000000;
        end
    end
    assign rdata = rdata_q;

    // clock configuration outputs
    assign div_raw = div_q[`ACKC_DIV_MSB:`ACKC_DIV_LSB];
    always_comb begin
        clk_cfg.sys_src = ackc_src_type'(sel_q[`ACKC_SEL_MSB:`ACKC_SEL_LSB]);
        if (lp_clk_active) begin
            clk_cfg.sys_src = ACKC_SRC_SLOW_OSC;
        end
        if (div_raw < `ACKC_DIV_MIN) begin
            clk_cfg.sys_div = `ACKC_DIV_MIN;
        end else if (div_raw > `ACKC_DIV_MAX) begin
            clk_cfg.sys_div = `ACKC_DIV_MAX;
        end else begin
            clk_cfg.sys_div = div_raw;
        end
        clk_cfg.fast_32m = fast_q[`ACKC_FAST_32M_BIT];
        clk_cfg.adc_32m = fast_q[`ACKC_FAST_32M_BIT];
        clk_cfg.lp_clk_allow = lpclk_q[`ACKC_LP_CLK_BIT];
        clk_cfg.pd_mask = lppd_q;
    end

    assign lp_clk_active = seq_lp_req && lpclk_q[`ACKC_LP_CLK_BIT];
    assign ext_clk_pin_a_sel = clk_cfg.sys_src == ACKC_SRC_EXT_CLK;
    assign ext_clk_pin_b_sel = 1'b0 & PIN_B_PRESENT;
    assign wakeup_timer_tick = slow_osc_tick;

    osc_lock_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_osc_ctl && !osc_unlk_q) |=> osc_q == $past(osc_q))
        else $error("locked oscillator write changed value");
    osc_relock_a: assert property (@(posedge core_clk) disable iff (rst)
        (bus.wr && !wr_osc_key) |=> !osc_unlk_q)
        else $error("oscillator key not relocked");
    osc_key_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_osc_key && bus.wdata[15:0] == `ACKC_OSC_UNLOCK) ##1 wr_osc_ctl
        |=> osc_q == $past(bus.wdata[15:0]))
        else $error("unlocked oscillator write lost");
    lp_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        (bus.wr && bus.addr == `ACKC_ADR_LP_PD && !lp_unlk_q) |=> $stable(lppd_q))
        else $error("locked power-down write took effect");
    div_range_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_cfg.sys_div >= `ACKC_DIV_MIN && clk_cfg.sys_div <= `ACKC_DIV_MAX)
        else $error("divider out of range");
    lp_switch_a: assert property (@(posedge core_clk) disable iff (rst)
        (seq_lp_req && lpclk_q[`ACKC_LP_CLK_BIT]) |-> clk_cfg.sys_src == ACKC_SRC_SLOW_OSC)
        else $error("slow clock switch missing");
    adc_path_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_cfg.adc_32m == clk_cfg.fast_32m)
        else $error("adc clock not following source");
    read_data_a: assert property (@(posedge core_clk) disable iff (rst)
        (bus.rd && bus.addr == `ACKC_ADR_LP_PD) |=> rdata == $past(lppd_q))
        else $error("read data wrong");
    lp_clk_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_lp_clk && !lp_unlk_q) |=> $stable(lpclk_q))
        else $error("locked low power clock write took effect");
    lp_clk_write_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_lp_clk && lp_unlk_q) |=> lpclk_q == $past(bus.wdata))
        else $error("unlocked low power clock write lost");
    lp_pd_write_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_lp_pd && lp_unlk_q) |=> lppd_q == $past(bus.wdata))
        else $error("unlocked power-down write lost");
    osc_bad_key_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_osc_key && bus.wdata[15:0] != `ACKC_OSC_UNLOCK) |=> !osc_unlk_q)
        else $error("wrong oscillator key unlocked");
    lp_key_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        !wr_lp_key |=> lp_unlk_q == $past(lp_unlk_q))
        else $error("low power lock changed without key write");
    lp_bad_key_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_lp_key && bus.wdata != `ACKC_LP_UNLOCK) |=> !lp_unlk_q)
        else $error("wrong low power key unlocked");
    rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
        !bus.rd |=> rdata == 32'h00000000)
        else $error("read data without read");
    read_osc_a: assert property (@(posedge core_clk) disable iff (rst)
        (bus.rd && bus.addr == `ACKC_ADR_OSC_CTL) |=> rdata == {16'h0000, $past(osc_q)})
        else $error("oscillator control read wrong");
    read_lpclk_a: assert property (@(posedge core_clk) disable iff (rst)
        (bus.rd && bus.addr == `ACKC_ADR_LP_CLK) |=> rdata == $past(lpclk_q))
        else $error("low power clock read wrong");
    read_key_a: assert property (@(posedge core_clk) disable iff (rst)
        (bus.rd && bus.addr == `ACKC_ADR_OSC_KEY) |=> rdata == 32'h00000000)
        else $error("key register read not zero");
    src_default_a: assert property (@(posedge core_clk) disable iff (rst)
        (sel_q[`ACKC_SEL_MSB:`ACKC_SEL_LSB] == 2'b00 && !lp_clk_active)
        |-> clk_cfg.sys_src == ACKC_SRC_FAST_OSC)
        else $error("default source not fast oscillator");
    div_pass_a: assert property (@(posedge core_clk) disable iff (rst)
        (div_raw >= `ACKC_DIV_MIN && div_raw <= `ACKC_DIV_MAX) |-> clk_cfg.sys_div == div_raw)
        else $error("divider not passed through");
    div_low_a: assert property (@(posedge core_clk) disable iff (rst)
        div_raw < `ACKC_DIV_MIN |-> clk_cfg.sys_div == `ACKC_DIV_MIN)
        else $error("divider low clamp wrong");
    div_high_a: assert property (@(posedge core_clk) disable iff (rst)
        div_raw > `ACKC_DIV_MAX |-> clk_cfg.sys_div == `ACKC_DIV_MAX)
        else $error("divider high clamp wrong");
    pin_a_slow_a: assert property (@(posedge core_clk) disable iff (rst)
        lp_clk_active |-> !ext_clk_pin_a_sel)
        else $error("external pin selected in slow clock");
    pin_b_a: assert property (@(posedge core_clk) disable iff (rst)
        !ext_clk_pin_b_sel || PIN_B_PRESENT)
        else $error("absent pin b selected");
    wake_tick_a: assert property (@(posedge core_clk) disable iff (rst)
        wakeup_timer_tick == slow_osc_tick)
        else $error("wake tick not from slow oscillator");
    pd_mask_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_cfg.pd_mask == lppd_q)
        else $error("power-down mask not driven");

    osc_unlock_c: cover property (@(posedge core_clk) disable iff (rst)
        wr_osc_key ##1 wr_osc_ctl);
    lp_unlock_c: cover property (@(posedge core_clk) disable iff (rst)
        wr_lp_key ##1 (bus.wr && bus.addr == `ACKC_ADR_LP_CLK));
    lp_active_c: cover property (@(posedge core_clk) disable iff (rst) lp_clk_active);
    div_clamp_c: cover property (@(posedge core_clk) disable iff (rst)
        div_raw < `ACKC_DIV_MIN);
    osc_relock_c: cover property (@(posedge core_clk) disable iff (rst)
        wr_osc_key ##1 (bus.wr && !wr_osc_ctl));
endmodule

// *** test/afe_clock_and_key_control_tb_top.sv ***
`timescale 1ns/10ps
`include "ackc_consts.svh"
module afe_clock_and_key_control_tb_top;
    import ackc_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    ackc_bus_type bus = '0;
    logic [31:0] rdata;
    logic slow_osc_tick = 1'b0;
    logic seq_lp_req = 1'b0;
    ackc_clk_type clk_cfg;
    logic pin_a;
    logic pin_b;
    logic tick;
    logic lp_act;
    int n_errors = 0;
    int checks_done = 0;
    logic [31:0] rd_val;
    logic [31:0] r;
    logic [5:0] f;
    logic [15:0] adr_tab [12] = '{`ACKC_ADR_CLK_DIV, `ACKC_ADR_CLK_GATE, `ACKC_ADR_CLK_SEL,
        `ACKC_ADR_OSC_CTL, `ACKC_ADR_SLOW_TRIM, `ACKC_ADR_CHOP_EN, `ACKC_ADR_FAST_CFG,
        `ACKC_ADR_LP_CLK, `ACKC_ADR_LP_PD, `ACKC_ADR_OSC_KEY, `ACKC_ADR_LP_KEY, 16'h0004};
    logic [31:0] rst_tab [12] = '{`ACKC_RST_CLK_DIV, `ACKC_RST_CLK_GATE, `ACKC_RST_CLK_SEL,
        `ACKC_RST_OSC_CTL, `ACKC_RST_SLOW_TRIM, `ACKC_RST_CHOP_EN, `ACKC_RST_FAST_CFG,
        `ACKC_RST_LP_CLK, `ACKC_RST_LP_PD, 32'h0, 32'h0, 32'h0};

    ackc_clock_key u_dut (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .slow_osc_tick(slow_osc_tick), .seq_lp_req(seq_lp_req), .clk_cfg(clk_cfg),
        .ext_clk_pin_a_sel(pin_a), .ext_clk_pin_b_sel(pin_b), .wakeup_timer_tick(tick),
        .lp_clk_active(lp_act));

    always #25 core_clk = ~core_clk;

    function automatic logic [31:0] exp_src(input logic [1:0] s);
        return {30'h0, s};
    endfunction

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '0;
        #1;
    endtask

    task rd(input logic [15:0] a);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '0;
        #1 rd_val = rdata;
    endtask

    task close_out;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h0d031a1b));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            rd(adr_tab[i]);
            chk("reset value", rd_val, rst_tab[i]);
        end
        chk("reset source", clk_cfg.sys_src, ACKC_SRC_FAST_OSC);
        $display("test reset values done");
        r = {16'h0, 16'($urandom)};
        wr(`ACKC_ADR_OSC_CTL, r);
        rd(`ACKC_ADR_OSC_CTL);
        chk("osc ctl locked", rd_val, `ACKC_RST_OSC_CTL);
        wr(`ACKC_ADR_OSC_KEY, `ACKC_OSC_UNLOCK);
        wr(`ACKC_ADR_OSC_CTL, r);
        rd(`ACKC_ADR_OSC_CTL);
        chk("osc ctl unlocked", rd_val, r);
        wr(`ACKC_ADR_OSC_KEY, `ACKC_OSC_UNLOCK);
        wr(`ACKC_ADR_CLK_GATE, `ACKC_RST_CLK_GATE);
        wr(`ACKC_ADR_OSC_CTL, ~r);
        rd(`ACKC_ADR_OSC_CTL);
        chk("osc ctl relocked", rd_val, r);
        wr(`ACKC_ADR_OSC_KEY, 32'h0000cb15);
        wr(`ACKC_ADR_OSC_CTL, ~r);
        rd(`ACKC_ADR_OSC_CTL);
        chk("osc ctl bad key", rd_val, r);
        $display("test oscillator key done");
        @(posedge core_clk) seq_lp_req <= 1'b1;
        wr(`ACKC_ADR_LP_CLK, 32'h1);
        chk("lp clk locked", clk_cfg.lp_clk_allow, 1'b0);
        wr(`ACKC_ADR_LP_KEY, `ACKC_LP_UNLOCK);
        wr(`ACKC_ADR_LP_CLK, 32'h1);
        chk("lp clk allow", clk_cfg.lp_clk_allow, 1'b1);
        chk("lp clk active", lp_act, 1'b1);
        r = $urandom;
        wr(`ACKC_ADR_LP_PD, r);
        chk("pd mask", clk_cfg.pd_mask, r);
        wr(`ACKC_ADR_LP_KEY, 32'h0);
        wr(`ACKC_ADR_LP_PD, ~r);
        chk("pd mask locked", clk_cfg.pd_mask, r);
        @(posedge core_clk) seq_lp_req <= 1'b0;
        #1 chk("lp clk idle", lp_act, 1'b0);
        $display("test low power key done");
        wr(`ACKC_ADR_CLK_DIV, {26'h11, 6'h00});
        chk("divider low clamp", clk_cfg.sys_div, `ACKC_DIV_MIN);
        wr(`ACKC_ADR_CLK_DIV, {26'h11, 6'h3f});
        chk("divider high clamp", clk_cfg.sys_div, `ACKC_DIV_MAX);
        for (int i = 0; i < 10; i++) begin
            f = (i == 0) ? 6'h01 : (i == 1) ? 6'h20 : 6'($urandom_range(32, 1));
            wr(`ACKC_ADR_CLK_DIV, {26'h11, f});
            chk("divider", clk_cfg.sys_div, f);
        end
        for (int s = 0; s < 4; s++) begin
            wr(`ACKC_ADR_CLK_SEL, s);
            chk("source", clk_cfg.sys_src, exp_src(2'(s)));
            chk("ext pin a", pin_a, s == 2);
            chk("ext pin b", pin_b, 1'b0);
        end
        wr(`ACKC_ADR_CLK_SEL, 32'h0);
        wr(`ACKC_ADR_CLK_DIV, {26'h11, 6'h02});
        chk("divider 32m source", clk_cfg.sys_div, 6'h02);
        wr(`ACKC_ADR_FAST_CFG, 32'h34);
        chk("fast 32m", clk_cfg.fast_32m, 1'b1);
        chk("adc 32m", clk_cfg.adc_32m, 1'b1);
        wr(`ACKC_ADR_FAST_CFG, 32'h30);
        chk("adc 16m", clk_cfg.adc_32m, 1'b0);
        $display("test clock path done");
        repeat (20) begin
            @(posedge core_clk) slow_osc_tick <= 1'($urandom);
            #1 chk("wake tick", tick, slow_osc_tick);
        end
        $display("test wake tick done");
        @(posedge core_clk) rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(`ACKC_ADR_LP_PD);
        chk("pd after reset", rd_val, `ACKC_RST_LP_PD);
        wr(`ACKC_ADR_OSC_CTL, 32'h0);
        rd(`ACKC_ADR_OSC_CTL);
        chk("osc after reset", rd_val, `ACKC_RST_OSC_CTL);
        chk("src after reset", clk_cfg.sys_src, ACKC_SRC_FAST_OSC);
        $display("test mid reset done");
        close_out;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        close_out;
    end
endmodule
